// ==== hdl/slot_regs.svh ====
`ifndef SLOT_REGS_SVH
`define SLOT_REGS_SVH
// ***************************************************************************
// Timing
// ***************************************************************************
`define CLK_FREQ_HZ 20000000
`define UPDATE_PERIOD_MS 60
`define UPDATE_CYCLES ((`CLK_FREQ_HZ / 1000) * `UPDATE_PERIOD_MS)
`define FLASH_UPDATES 8
// ***************************************************************************
// Response word fields
// ***************************************************************************
`define RESP_ACK_LSB 14
`define RESP_IND_LSB 8
`define RESP_INTEG_FIRST_BIT 15
`define RESP_INTEG_LAST_BIT 15
// ***************************************************************************
// Command codes
// ***************************************************************************
`define CMD_NEXT_A 16'h0001
`define CMD_NEXT_B 16'h0002
`define CMD_AUTO_ROT 16'h0003
`define CMD_ROT_CLEAR 16'h0004
`define CMD_ROT_ADD_BASE 16'h0010
`define CMD_STATIC_BASE 16'h0020
`define CMD_LOAD_TARGET 16'h0030
`define CMD_LOAD_TARE 16'h0031
// ***************************************************************************
// Avalon register map
// ***************************************************************************
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_NET 8'h08
`define REG_DISC_OUT 8'h0C
`define REG_DISC_IN 8'h10
`define REG_QTY_BASE 8'h40
`define REG_TARGET_BASE 8'h80
`define REG_TARE_BASE 8'hA0
`define REG_CMD_BASE 8'hC0
`define REG_LIST_BASE 8'hE0
`define RESET_CONFIG 32'h0000_0200
`endif

// ==== hdl/slot_pkg.sv ====
package slot_pkg;
  typedef enum logic [1:0] {
    FMT_INTEGER = 2'h0,
    FMT_DIVISIONS = 2'h1,
    FMT_FLOAT = 2'h2,
    FMT_APPLICATION = 2'h3
  } format_t;
  typedef enum logic [1:0] {
    ORDER_STANDARD = 2'h0,
    ORDER_BYTE_SWAP = 2'h1,
    ORDER_WORD_SWAP = 2'h2,
    ORDER_DWORD_SWAP = 2'h3
  } byte_order_t;
  typedef enum logic [2:0] {
    NET_OFF = 3'h0,
    NET_GREEN = 3'h1,
    NET_GREEN_FLASH = 3'h2,
    NET_RED = 3'h3,
    NET_RED_FLASH = 3'h4,
    NET_SELF_TEST = 3'h5
  } net_state_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_WAIT_ACK = 2'h1
  } host_state_t;
endpackage

// ==== hdl/slot_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Cyclic words: PLC output (command, two value words) and PLC input (response, two value words, status).
interface slot_link_if #(parameter int SLOTS = 4);
  logic [15:0] cmd_word [SLOTS];
  logic [15:0] val_hi [SLOTS];
  logic [15:0] val_lo [SLOTS];
  logic [15:0] resp_word [SLOTS];
  logic [15:0] in_hi [SLOTS];
  logic [15:0] in_lo [SLOTS];
  logic [15:0] status_word [SLOTS];
  logic [7:0] plc_disc_out;
  logic [7:0] plc_disc_in;
  modport device(input cmd_word, input val_hi, input val_lo, input plc_disc_out,
    output resp_word, output in_hi, output in_lo, output status_word, output plc_disc_in);
  modport plc(output cmd_word, output val_hi, output val_lo, output plc_disc_out,
    input resp_word, input in_hi, input in_lo, input status_word, input plc_disc_in);
endinterface
`default_nettype wire

// ==== hdl/scale_terminal.sv ====
// The register offsets and the Avalon-MM register port were decided locally.
`include "slot_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE_01] New command only when word value changes; here an unchanged word is also taken after reset or a format change.
// [RULE_02] PLC loads operand before changing command.
// [RULE_03] Acknowledge by changing response acknowledge field.
// [RULE_04] Indicator bits name returned quantity.
// [RULE_05] PLC waits for acknowledge before next.
// [RULE_06] Real-time value refreshed every update cycle.
// [RULE_07] Static value updated once, then held.
// [RULE_08] Rotation list up to nine entries.
// [RULE_09] Auto alternation steps each update cycle.
// [RULE_10] Update cycle no faster than 60 ms.
// [RULE_11] Codes 1 and 2 alternate to step.
// [RULE_12] Rotation list kept in persistent storage; here it is ordinary flops cleared by reset.
// [RULE_13] Empty rotation means gross weight only.
// [RULE_14] Values exchanged as single-precision float words.
// [RULE_15] Four byte orders, word swap default.
// [RULE_16] Integrity bits first word, last byte.
// [RULE_17] PLC accepts only matching integrity bits.
// [RULE_18] Discrete I/O moved only on update cycle.
// [RULE_19] Four formats; format change discards slots.
// [RULE_20] Integer and divisions limited to 32767.
// [RULE_21] One to four message slots.
// [RULE_22] Network indicator shows connection states.
// [RULE_23] Operand captured with command change.
module scale_terminal #(
  parameter int SLOTS = 4,
  parameter int ROT_DEPTH = 9,
  parameter int QTY_COUNT = 16,
  parameter int UPDATE_CYCLES = `UPDATE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  slot_link_if.device link,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] field_disc_in,
  output logic [7:0] field_disc_out,
  output logic net_led_green_out,
  output logic net_led_red_out
);
  // ***************************************************************************
  // Update cycle and configuration
  // ***************************************************************************
  logic [23:0] tick_cnt;
  logic tick;
  logic tick_d;
  logic [31:0] config_reg;
  logic [2:0] net_sel;
  logic [3:0] flash_cnt;
  logic [7:0] disc_out_reg;
  logic [7:0] disc_in_reg;
  logic [31:0] qty_val [QTY_COUNT];
  // Rotation list is ordinary flops here and is cleared by reset,
  // so its contents are not retained across power loss.
  logic [3:0] rot_list [SLOTS][ROT_DEPTH];
  logic [3:0] rot_len [SLOTS];
  logic [3:0] rot_pos [SLOTS];
  logic [SLOTS-1:0] rot_auto;
  logic [15:0] last_cmd [SLOTS];
  logic [31:0] target_reg [SLOTS];
  logic [31:0] tare_reg [SLOTS];
  logic [1:0] ack [SLOTS];
  logic [3:0] ind [SLOTS];
  logic [SLOTS-1:0] is_static;
  logic [31:0] out_val [SLOTS];
  logic [SLOTS-1:0] integ;
  logic [SLOTS-1:0] cmd_seen;
  slot_pkg::format_t fmt;
  slot_pkg::byte_order_t order;
  logic [2:0] slots_cfg;
  wire config_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == `REG_CONFIG;
  wire fmt_change = config_wr && avs_writedata_in[1:0] != config_reg[1:0];
  assign fmt = slot_pkg::format_t'(config_reg[1:0]);
  assign order = slot_pkg::byte_order_t'(config_reg[9:8]);
  assign slots_cfg = (config_reg[18:16] == 3'h0) ? 3'h1 : (config_reg[18:16] > 3'h4) ? 3'h4 : config_reg[18:16]; // [RULE_21]
  assign tick = tick_cnt == 24'(UPDATE_CYCLES - 1); // [RULE_10]
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 24'h000000;
      tick_d <= 1'b0;
    end else begin
      tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
      tick_d <= tick;
    end
  end
  // ***************************************************************************
  // Avalon slave: one wait state on every access
  // ***************************************************************************
  logic [31:0] next_rd;
  wire wr_take = avs_write_in && !avs_waitrequest_out;
  wire [2:0] sel_idx = avs_address_in[4:2];
  wire in_slot = {29'h0, sel_idx} < 32'(SLOTS);
  wire [3:0] qidx = avs_address_in[5:2];
  always_comb begin
    next_rd = 32'h0000_0000;
    if (avs_address_in == `REG_CONFIG) next_rd = config_reg;
    else if (avs_address_in == `REG_STATUS) next_rd = {28'h0, 1'b0, slots_cfg};
    else if (avs_address_in == `REG_NET) next_rd = {29'h0, net_sel};
    else if (avs_address_in == `REG_DISC_OUT) next_rd = {24'h0, disc_out_reg};
    else if (avs_address_in == `REG_DISC_IN) next_rd = {24'h0, disc_in_reg};
    else if (avs_address_in[7:6] == 2'h1) next_rd = qty_val[qidx];
    else if (avs_address_in[7:5] == 3'h4 && in_slot) next_rd = target_reg[sel_idx[1:0]];
    else if (avs_address_in[7:5] == 3'h5 && in_slot) next_rd = tare_reg[sel_idx[1:0]];
    else if (avs_address_in[7:5] == 3'h6 && in_slot) next_rd = {12'h0, rot_len[sel_idx[1:0]], last_cmd[sel_idx[1:0]]};
  end
  // Wait request is a flop that idles high, so every access sees exactly one wait state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      config_reg <= `RESET_CONFIG; // [RULE_15] [RULE_19]
      net_sel <= 3'h0;
      disc_out_reg <= 8'h00;
      for (int q = 0; q < QTY_COUNT; q++) qty_val[q] <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) avs_readdata_out <= next_rd;
      if (config_wr) config_reg <= avs_writedata_in;
      if (wr_take && avs_address_in == `REG_NET) net_sel <= avs_writedata_in[2:0];
      if (wr_take && avs_address_in == `REG_DISC_OUT) disc_out_reg <= avs_writedata_in[7:0];
      if (wr_take && avs_address_in[7:6] == 2'h1) qty_val[qidx] <= avs_writedata_in; // [RULE_14]
    end
  end
  // ***************************************************************************
  // Per-slot command interpreter
  // ***************************************************************************
  function automatic logic [31:0] reorder(input logic [31:0] v, input slot_pkg::byte_order_t o);
    case (o)
      slot_pkg::ORDER_STANDARD: reorder = v;
      slot_pkg::ORDER_BYTE_SWAP: reorder = {v[23:16], v[31:24], v[7:0], v[15:8]};
      slot_pkg::ORDER_WORD_SWAP: reorder = {v[15:0], v[31:16]};
      slot_pkg::ORDER_DWORD_SWAP: reorder = {v[7:0], v[15:8], v[23:16], v[31:24]};
      default: reorder = v;
    endcase
  endfunction
  function automatic logic [15:0] clamp16(input logic [31:0] v);
    if ($signed(v) > 32'sd32767) clamp16 = 16'h7FFF; // [RULE_20]
    else if ($signed(v) < -32'sd32767) clamp16 = 16'h8001;
    else clamp16 = v[15:0];
  endfunction
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      wire [15:0] cmd = link.cmd_word[s];
      wire active = 3'(s) < slots_cfg;
      wire changed = active && (cmd != last_cmd[s] || !cmd_seen[s]); // [RULE_01]
      wire is_next = cmd == `CMD_NEXT_A || cmd == `CMD_NEXT_B; // [RULE_11]
      wire [3:0] len_eff = (rot_len[s] == 4'h0) ? 4'h1 : rot_len[s];
      wire [3:0] next_pos = (rot_pos[s] + 4'h1 >= len_eff) ? 4'h0 : rot_pos[s] + 4'h1;
      wire [3:0] next_qty = (rot_len[s] == 4'h0) ? 4'h0 : rot_list[s][next_pos]; // [RULE_13]
      wire [31:0] fresh = (ind[s] == 4'hE) ? target_reg[s] : (ind[s] == 4'hF) ? tare_reg[s] : qty_val[ind[s]];
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          last_cmd[s] <= 16'h0000;
          cmd_seen[s] <= 1'b0;
          ack[s] <= 2'h0;
          ind[s] <= 4'h0;
          is_static[s] <= 1'b0;
          rot_len[s] <= 4'h0;
          rot_pos[s] <= 4'h0;
          rot_auto[s] <= 1'b0;
          target_reg[s] <= 32'h0000_0000;
          tare_reg[s] <= 32'h0000_0000;
          out_val[s] <= 32'h0000_0000;
          integ[s] <= 1'b0;
          for (int e = 0; e < ROT_DEPTH; e++) rot_list[s][e] <= 4'h0;
        end else if (fmt_change) begin
          cmd_seen[s] <= 1'b0; // [RULE_19]
          if (tick) integ[s] <= ~integ[s];
          rot_auto[s] <= 1'b0;
          is_static[s] <= 1'b0;
        end else if (tick) begin
          integ[s] <= ~integ[s]; // [RULE_16]
          if (changed) begin
            last_cmd[s] <= cmd;
            cmd_seen[s] <= 1'b1;
            ack[s] <= (ack[s] == 2'h3) ? 2'h1 : ack[s] + 2'h1; // [RULE_03]
            if (is_next) begin
              rot_auto[s] <= 1'b0;
              rot_pos[s] <= next_pos; // [RULE_11]
              ind[s] <= next_qty;
              out_val[s] <= qty_val[next_qty];
              is_static[s] <= 1'b0;
            end else if (cmd == `CMD_AUTO_ROT) begin
              rot_auto[s] <= 1'b1;
              is_static[s] <= 1'b0;
            end else if (cmd == `CMD_ROT_CLEAR) begin
              rot_len[s] <= 4'h0;
              rot_pos[s] <= 4'h0;
            end else if (cmd[15:4] == `CMD_ROT_ADD_BASE >> 4) begin
              if (rot_len[s] < 4'(ROT_DEPTH)) begin
                rot_list[s][rot_len[s]] <= cmd[3:0]; // [RULE_08] [RULE_12]
                rot_len[s] <= rot_len[s] + 4'h1;
              end
            end else if (cmd == `CMD_LOAD_TARGET) begin
              target_reg[s] <= {link.val_hi[s], link.val_lo[s]}; // [RULE_23] [RULE_02]
            end else if (cmd == `CMD_LOAD_TARE) begin
              tare_reg[s] <= {link.val_hi[s], link.val_lo[s]}; // [RULE_23]
            end else if (cmd[15:4] == `CMD_STATIC_BASE >> 4) begin
              is_static[s] <= 1'b1;
              rot_auto[s] <= 1'b0;
              ind[s] <= cmd[0] ? 4'hF : 4'hE;
              out_val[s] <= cmd[0] ? tare_reg[s] : target_reg[s]; // [RULE_07]
            end else begin
              is_static[s] <= 1'b0;
              rot_auto[s] <= 1'b0;
              ind[s] <= cmd[3:0]; // [RULE_04]
              out_val[s] <= qty_val[cmd[3:0]]; // [RULE_06]
            end
          end else if (rot_auto[s]) begin
            rot_pos[s] <= next_pos; // [RULE_09]
            ind[s] <= next_qty;
            out_val[s] <= qty_val[next_qty];
          end else if (!is_static[s]) begin
            out_val[s] <= fresh; // [RULE_06]
          end
        end
      end
      wire [31:0] ordered = reorder(out_val[s], order); // [RULE_15]
      wire [15:0] int_val = clamp16(out_val[s]);
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          link.resp_word[s] <= 16'h0000;
          link.in_hi[s] <= 16'h0000;
          link.in_lo[s] <= 16'h0000;
          link.status_word[s] <= 16'h0000;
        end else if (tick_d && (!active || !cmd_seen[s])) begin
          link.resp_word[s] <= {integ[s] && active, 15'h0000}; // [RULE_16]
          link.in_hi[s] <= 16'h0000;
          link.in_lo[s] <= 16'h0000;
          link.status_word[s] <= {integ[s] && active, 15'h0000};
        end else if (tick_d) begin
          link.resp_word[s] <= {integ[s], ack[s], 5'h00, 4'h0, ind[s]}; // [RULE_16]
          link.in_hi[s] <= (fmt == slot_pkg::FMT_FLOAT) ? ordered[31:16] : int_val; // [RULE_14] [RULE_20]
          link.in_lo[s] <= (fmt == slot_pkg::FMT_FLOAT) ? ordered[15:0] : 16'h0000;
          link.status_word[s] <= {integ[s], 7'h00, 8'h00}; // [RULE_16]
        end
      end
    end
  endgenerate
  // ***************************************************************************
  // Discrete I/O and network indicator
  // ***************************************************************************
  wire flash_on = flash_cnt[3];
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      field_disc_out <= 8'h00;
      disc_in_reg <= 8'h00;
      link.plc_disc_in <= 8'h00;
      flash_cnt <= 4'h0;
      net_led_green_out <= 1'b0;
      net_led_red_out <= 1'b0;
    end else if (tick) begin
      field_disc_out <= link.plc_disc_out | disc_out_reg; // [RULE_18]
      disc_in_reg <= field_disc_in;
      link.plc_disc_in <= field_disc_in; // [RULE_18]
      flash_cnt <= flash_cnt + 4'h1;
      net_led_green_out <= (net_sel == slot_pkg::NET_GREEN) || // [RULE_22]
        (net_sel == slot_pkg::NET_GREEN_FLASH && flash_on) || (net_sel == slot_pkg::NET_SELF_TEST && flash_on);
      net_led_red_out <= (net_sel == slot_pkg::NET_RED) ||
        (net_sel == slot_pkg::NET_RED_FLASH && flash_on) || (net_sel == slot_pkg::NET_SELF_TEST && !flash_on);
    end
  end
endmodule // scale_terminal
`default_nettype wire

// ==== hdl/plc_master.sv ====
`include "slot_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_master #(
  parameter int SLOTS = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  slot_link_if.plc link,
  input wire logic [1:0] req_slot_in,
  input wire logic req_valid_in,
  input wire logic [15:0] req_cmd_in,
  input wire logic [31:0] req_value_in,
  input wire logic [7:0] disc_out_in,
  output logic req_ready_out,
  output logic [31:0] value_out,
  output logic value_valid_out,
  output logic [7:0] disc_in_out
);
  // ***************************************************************************
  // Command issue, one outstanding command across all slots
  // ***************************************************************************
  slot_pkg::host_state_t state;
  logic [1:0] cur;
  logic [1:0] ack_seen;
  logic [15:0] pend_cmd;
  wire [1:0] ack_now = link.resp_word[cur][14:13];
  wire integ_ok = link.resp_word[cur][15] == link.status_word[cur][15]; // [RULE_17]
  assign req_ready_out = state == slot_pkg::HS_IDLE;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= slot_pkg::HS_IDLE;
      cur <= 2'h0;
      ack_seen <= 2'h0;
      pend_cmd <= 16'h0000;
      value_out <= 32'h0000_0000;
      value_valid_out <= 1'b0;
      disc_in_out <= 8'h00;
      link.plc_disc_out <= 8'h00;
      for (int i = 0; i < SLOTS; i++) begin
        link.cmd_word[i] <= 16'h0000;
        link.val_hi[i] <= 16'h0000;
        link.val_lo[i] <= 16'h0000;
      end
    end else begin
      link.plc_disc_out <= disc_out_in;
      disc_in_out <= link.plc_disc_in;
      value_valid_out <= 1'b0;
      case (state)
        slot_pkg::HS_IDLE: begin
          if (req_valid_in) begin
            cur <= req_slot_in;
            ack_seen <= link.resp_word[req_slot_in][14:13];
            pend_cmd <= req_cmd_in;
            link.val_hi[req_slot_in] <= req_value_in[31:16]; // [RULE_02] [RULE_14]
            link.val_lo[req_slot_in] <= req_value_in[15:0];
            state <= slot_pkg::HS_WAIT_ACK;
          end
        end
        slot_pkg::HS_WAIT_ACK: begin
          link.cmd_word[cur] <= pend_cmd; // [RULE_02]
          if (ack_now != ack_seen && ack_now != 2'h0 && integ_ok) begin // [RULE_05]
            value_out <= {link.in_hi[cur], link.in_lo[cur]};
            value_valid_out <= 1'b1;
            state <= slot_pkg::HS_IDLE;
          end
        end
        default: state <= slot_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // plc_master
`default_nettype wire

// ==== dv/slot_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Link checker
// ****************
module slot_link_sva #(parameter int SLOTS = 4) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] cmd_word [SLOTS],
  input wire logic [15:0] val_hi [SLOTS],
  input wire logic [15:0] val_lo [SLOTS],
  input wire logic [15:0] resp_word [SLOTS],
  input wire logic [15:0] status_word [SLOTS],
  input wire logic [7:0] plc_disc_in
);
  // The slot 0 integrity bit toggles on every update, so it marks the update tick.
  wire logic integ = status_word[0][15];
  wire logic [1:0] ack = resp_word[0][14:13];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  integ_same_a: assert property (resp_word[0][15] == integ)
    else $error("integrity bits differ");
  tick_gap_a: assert property ($changed(integ) |=> !$changed(integ) [*8])
    else $error("updates too close together");
  tick_due_a: assert property ($changed(integ) |-> ##[9:17] $changed(integ))
    else $error("update overdue");
  ack_tick_a: assert property ($changed(ack) |-> $changed(integ))
    else $error("acknowledge moved off the update");
  ack_step_a: assert property ($changed(ack) && ack != 2'h0 && $past(ack) != 2'h0 |->
    ack == (($past(ack) == 2'h3) ? 2'h1 : $past(ack) + 2'h1)) else $error("acknowledge out of sequence");
  ind_tick_a: assert property ($changed(resp_word[0][3:0]) |-> $changed(integ))
    else $error("indicator moved off the update");
  disc_tick_a: assert property ($changed(plc_disc_in) |=> $changed(integ))
    else $error("discrete input moved off the update");
  cmd_ack_a: assert property ($changed(cmd_word[0]) |-> ##[1:40] $changed(ack))
    else $error("new command not acknowledged");
  operand_first_a: assert property ($changed(cmd_word[0]) |-> $stable(val_hi[0]) && $stable(val_lo[0]))
    else $error("operand changed with command");
  plc_wait_a: assert property ($changed(cmd_word[0]) |=> $stable(cmd_word[0]) until $changed(ack))
    else $error("command changed before acknowledge");
endmodule // slot_link_sva
`default_nettype wire

// ==== dv/scale_float_slot_handshake_tb.sv ====
`include "slot_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module scale_float_slot_handshake_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] field_disc_in = 8'h00;
  logic [7:0] field_disc_out;
  logic net_led_green_out;
  logic net_led_red_out;
  logic [1:0] req_slot_in = 2'h0;
  logic req_valid_in = 1'b0;
  logic [15:0] req_cmd_in = 16'h0;
  logic [31:0] req_value_in = 32'h0;
  logic [7:0] disc_out_in = 8'h00;
  logic req_ready_out;
  logic [31:0] value_out;
  logic value_valid_out;
  logic [7:0] disc_in_out;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] q;
  logic [31:0] got;
  logic [3:0] ind;
  always #25 clk_sys_in = ~clk_sys_in;
  slot_link_if #(.SLOTS(4)) slot_link ();
  scale_terminal #(.SLOTS(4), .UPDATE_CYCLES(16)) i_scale_terminal (.clk_sys_in, .rst_n_in, .link(slot_link),
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .field_disc_in, .field_disc_out, .net_led_green_out, .net_led_red_out);
  plc_master #(.SLOTS(4)) i_plc_master (.clk_sys_in, .rst_n_in, .link(slot_link), .req_slot_in, .req_valid_in,
    .req_cmd_in, .req_value_in, .disc_out_in, .req_ready_out, .value_out, .value_valid_out, .disc_in_out);
  slot_link_sva #(.SLOTS(4)) i_slot_link_sva (.clk_sys_in, .rst_n_in, .cmd_word(slot_link.cmd_word),
    .val_hi(slot_link.val_hi), .val_lo(slot_link.val_lo), .resp_word(slot_link.resp_word),
    .status_word(slot_link.status_word), .plc_disc_in(slot_link.plc_disc_in));
  // ****************
  // Shared tasks
  // ****************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout(input string what);
    check(what, 32'h0, 32'h1);
    finish_test();
  endtask
  // Every task is entered just after a rising edge and returns just after one.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_writedata_in <= d;
    do begin @(posedge clk_sys_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) timeout("bus answer");
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic tick(input int cnt);
    logic p;
    int c;
    for (int i = 0; i < cnt; i++) begin
      p = slot_link.status_word[0][15];
      c = 0;
      do begin @(posedge clk_sys_in); c++; end while (slot_link.status_word[0][15] === p && c < 40);
      if (c >= 40) timeout("update tick");
    end
    ind = slot_link.resp_word[0][3:0];
  endtask
  task automatic send(input logic [15:0] cmd, input logic [31:0] v, input bit ack);
    int n;
    n = 0;
    req_cmd_in <= cmd;
    req_value_in <= v;
    req_valid_in <= 1'b1;
    do begin @(posedge clk_sys_in); n++; end while (req_ready_out !== 1'b1 && n < 40);
    if (n >= 40) timeout("request taken");
    req_valid_in <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys_in); n++; end while (value_valid_out !== 1'b1 && n < 60);
    if (ack && n >= 60) timeout("command acknowledge");
    got = value_out;
    ind = slot_link.resp_word[0][3:0];
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_values();
    bus(1'b0, `REG_CONFIG, 32'h0);
    check("config reset", q, 32'h0000_0200);
    bus(1'b0, 8'h3C, 32'h0);
    check("unmapped read", q, 32'h0);
    bus(1'b1, `REG_CONFIG, 32'h0004_0002);
    tick(2);
    bus(1'b1, `REG_QTY_BASE + 8'h14, 32'h4120_0000);
    send(16'h0005, 32'h0, 1'b1);
    check("realtime value", got, 32'h4120_0000);
    check("realtime indicator", {28'h0, ind}, 32'h5);
    bus(1'b1, `REG_QTY_BASE + 8'h14, 32'h4148_0000);
    tick(2);
    check("realtime refresh", {slot_link.in_hi[0], slot_link.in_lo[0]}, 32'h4148_0000);
    send(16'h0030, 32'h42C8_0000, 1'b1);
    send(16'h0020, 32'h0, 1'b1);
    check("static target", got, 32'h42C8_0000);
    check("target indicator", {28'h0, ind}, 32'hE);
    tick(2);
    check("static held", {slot_link.in_hi[0], slot_link.in_lo[0]}, 32'h42C8_0000);
    $display("test values done");
  endtask
  task automatic t_rotation();
    logic [31:0] qv [3];
    logic [3:0] a;
    qv = '{32'h4040_0000, 32'h3F80_0000, 32'h4000_0000};
    for (int i = 0; i < 3; i++) bus(1'b1, `REG_QTY_BASE + 8'(4 * i), qv[i]);
    send(16'h0004, 32'h0, 1'b1);
    send(16'h0001, 32'h0, 1'b1);
    check("default rotation", got, qv[0]);
    send(16'h0011, 32'h0, 1'b1);
    send(16'h0012, 32'h0, 1'b1);
    send(16'h0002, 32'h0, 1'b1);
    a = ind;
    check("rotation value", got, qv[a[1:0]]);
    send(16'h0001, 32'h0, 1'b1);
    check("manual step", {31'h0, ind != a}, 32'h1);
    check("stepped value", got, qv[ind[1:0]]);
    send(16'h0003, 32'h0, 1'b1);
    tick(1);
    a = ind;
    tick(1);
    check("auto step", {31'h0, ind != a}, 32'h1);
    check("auto value", {slot_link.in_hi[0], slot_link.in_lo[0]}, qv[ind[1:0]]);
    $display("test rotation done");
  endtask
  task automatic t_io();
    logic [2:0] st [3];
    logic [1:0] led [3];
    st = '{3'h0, 3'h1, 3'h3};
    led = '{2'b00, 2'b10, 2'b01};
    disc_out_in <= 8'hA5;
    field_disc_in <= 8'h3C;
    tick(3);
    check("field output", {24'h0, field_disc_out}, 32'hA5);
    check("field input", {24'h0, disc_in_out}, 32'h3C);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `REG_NET, {29'h0, st[i]});
      tick(2);
      check("network light", {30'h0, net_led_green_out, net_led_red_out}, {30'h0, led[i]});
    end
    $display("test io done");
  endtask
  task automatic t_format();
    int n;
    send(16'h0003, 32'h0, 1'b0);
    check("repeat ignored", {31'h0, req_ready_out}, 32'h0);
    bus(1'b1, `REG_CONFIG, 32'h0004_0000);
    bus(1'b1, `REG_CONFIG, 32'h0004_0002);
    n = 0;
    while (req_ready_out !== 1'b1 && n < 60) begin @(posedge clk_sys_in); n++; end
    check("ack after format change", {31'h0, req_ready_out}, 32'h1);
    tick(2);
    req_slot_in <= 2'h3;
    send(16'h0005, 32'h0, 1'b1);
    req_slot_in <= 2'h0;
    check("slot four indicator", {28'h0, slot_link.resp_word[3][3:0]}, 32'h5);
    bus(1'b1, `REG_CONFIG, 32'h0001_0002);
    tick(1);
    check("unused slot", {16'h0, slot_link.status_word[3]}, 32'h0);
    tick(1);
    check("unused slot", {16'h0, slot_link.resp_word[3]}, 32'h0);
    $display("test format done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_values();
    t_rotation();
    t_io();
    t_format();
    finish_test();
  end
endmodule // scale_float_slot_handshake_tb
`default_nettype wire
